// ==== src/sfm_config_top.sv ====
`timescale 1ns/10ps
module sfm_config_top
    import sfm_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              rx_bit,
    input  wire logic              rx_bit_valid,
    input  wire logic              carrier_sense,
    output logic                   sync_found,
    input  wire logic              tx_start,
    output logic [7:0]             tx_byte,
    output logic                   tx_byte_valid,
    input  wire logic              tx_byte_ready,
    output logic                   tx_busy,
    output logic                   payload_fec_on,
    input  wire logic [23:0]       base_freq_word,
    output logic [11:0]            channel_spacing_word,
    output logic [27:0]            oper_freq_word
);
    generate
        if (ADDR_W < 16) begin : g_bad_addr
            $error("ADDR_W must be at least 16");
        end
    endgenerate

    logic [2:0]  sync_mode_reg;
    logic        fec_reg;
    logic [2:0]  pre_reg;
    logic [1:0]  exp_reg;
    logic [7:0]  mant_reg;
    logic [7:0]  sync_hi_reg;
    logic [7:0]  sync_lo_reg;
    logic [7:0]  channel_number_reg;
    logic        seen_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [11:0] spacing_reg;
    logic [27:0] oper_reg;
    logic        fec_out_reg;
    logic        req;
    logic        wr_en;
    logic [15:0] idx;
    logic        sync_pulse;
    logic        wr_mode;
    logic        wr_pfe;
    logic        wr_mant;
    logic        wr_hi;
    logic        wr_lo;
    logic        wr_channel_number;
    logic        wr_stat;

    sfm_cfg_if cfg_bus ();

    assign cfg_bus.sync_mode     = sync_mode_reg;
    assign cfg_bus.preamble_code = pre_reg;
    assign cfg_bus.sync_word     = {sync_hi_reg, sync_lo_reg};

    sfm_sync_detect u_detect (
        .mclk          (mclk),
        .rst           (rst),
        .cfg           (cfg_bus.sink),
        .rx_bit        (rx_bit),
        .rx_bit_valid  (rx_bit_valid),
        .carrier_sense (carrier_sense),
        .sync_found    (sync_pulse)
    );

    sfm_tx_header u_txhdr (
        .mclk       (mclk),
        .rst        (rst),
        .cfg        (cfg_bus.sink),
        .start      (tx_start),
        .byte_data  (tx_byte),
        .byte_valid (tx_byte_valid),
        .byte_ready (tx_byte_ready),
        .busy       (tx_busy)
    );

    assign sync_found = sync_pulse;

    // bus: every access costs one wait cycle, answered on the second edge
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign wr_en           = avs_write && ack_reg;
    assign idx             = avs_address[15:0];
    assign avs_readdata    = rdata_reg;

    // one write strobe per mapped register, shared by logic and checks
    assign wr_mode = wr_en && (idx == SYNC_MODE_IDX);
    assign wr_pfe  = wr_en && (idx == PFE_IDX);
    assign wr_mant = wr_en && (idx == MANT_IDX);
    assign wr_hi   = wr_en && (idx == SYNC_HI_IDX);
    assign wr_lo   = wr_en && (idx == SYNC_LO_IDX);
    assign wr_channel_number = wr_en && (idx == CHANNEL_NUMBER_IDX);
    assign wr_stat = wr_en && (idx == STATUS_IDX);

    function automatic logic [7:0] reg_view(
        input logic [15:0] a,
        input logic [2:0]  sm,
        input logic        fe,
        input logic [2:0]  pc,
        input logic [1:0]  ex,
        input logic [7:0]  ma,
        input logic [7:0]  hi,
        input logic [7:0]  lo,
        input logic [7:0]  ch,
        input logic        se,
        input logic        bu
    );
        case (a)
            SYNC_MODE_IDX: return {5'h00, sm};
            PFE_IDX:       return {fe, pc, 2'b00, ex};
            MANT_IDX:      return ma;
            SYNC_HI_IDX:   return hi;
            SYNC_LO_IDX:   return lo;
            CHANNEL_NUMBER_IDX:      return ch;
            STATUS_IDX:    return {6'h00, bu, se};
            default:       return 8'h00;
        endcase
    endfunction

    always_ff @(posedge mclk) begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= req && !ack_reg;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            rdata_reg <= 32'h0000_0000;
        else if (avs_read && !ack_reg)
            rdata_reg <= {24'h000000, reg_view(idx, sync_mode_reg, fec_reg,
                pre_reg, exp_reg, mant_reg, sync_hi_reg, sync_lo_reg,
                channel_number_reg, seen_reg, tx_busy)};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_mode_reg <= SYNC_MODE_RST;
        end else if (wr_mode) begin
            sync_mode_reg <= avs_writedata[2:0];
        end
    end

    // reserved bits 3:2 have no storage, so writes to them vanish
    always_ff @(posedge mclk) begin
        if (rst) begin
            fec_reg <= FEC_RST;
            pre_reg <= PRE_RST;
            exp_reg <= EXP_RST;
        end else if (wr_pfe) begin
            fec_reg <= avs_writedata[FEC_BIT];
            pre_reg <= avs_writedata[PRE_LSB +: 3];
            exp_reg <= avs_writedata[EXP_LSB +: 2];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            mant_reg <= MANT_RST;
        else if (wr_mant)
            mant_reg <= avs_writedata[7:0];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_hi_reg <= SYNC_HI_RST;
            sync_lo_reg <= SYNC_LO_RST;
        end else begin
            if (wr_hi)
                sync_hi_reg <= avs_writedata[7:0];
            if (wr_lo)
                sync_lo_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            channel_number_reg <= CHANNEL_NUMBER_RST;
        else if (wr_channel_number)
            channel_number_reg <= avs_writedata[7:0];
    end

    // sticky sync flag: a new sync in the clearing cycle keeps it set
    always_ff @(posedge mclk) begin
        if (rst)
            seen_reg <= 1'b0;
        else if (sync_pulse)
            seen_reg <= 1'b1;
        else if (wr_stat && avs_writedata[ST_SEEN_BIT])
            seen_reg <= 1'b0;
    end

    // payload coder sits outside; this only steers it
    always_ff @(posedge mclk) begin
        if (rst)
            fec_out_reg <= FEC_RST;
        else
            fec_out_reg <= fec_reg;
    end

    assign payload_fec_on = fec_out_reg;

    // spacing in crystal/2^18 units; exponent at most 3 so 12 bits suffice
    always_ff @(posedge mclk) begin
        if (rst)
            spacing_reg <= (SPACING_BASE + {4'h0, MANT_RST}) << EXP_RST;
        else
            spacing_reg <= (SPACING_BASE + {4'h0, mant_reg}) << exp_reg;
    end

    assign channel_spacing_word = spacing_reg;

    // base word is in crystal/2^16 units, so it moves up two places
    always_ff @(posedge mclk) begin
        if (rst)
            oper_reg <= 28'h000_0000;
        else
            oper_reg <= {2'b00, base_freq_word, 2'b00}
                      + {8'h00, 20'(spacing_reg) * 20'(channel_number_reg)};
    end

    assign oper_freq_word = oper_reg;

    a_wait_first: assert property (@(posedge mclk) disable iff (rst)
        (req && !$past(req)) |-> avs_waitrequest)
        else $error("no wait on a fresh request");
    a_answer_next: assert property (@(posedge mclk) disable iff (rst)
        (req && avs_waitrequest) ##1 $stable(avs_address) && req |-> !avs_waitrequest)
        else $error("answer late");
    a_mode_reset: assert property (@(posedge mclk)
        $past(rst) |-> sync_mode_reg == 3'h2 && pre_reg == 3'h2)
        else $error("mode or preamble reset wrong");
    a_fec_follow: assert property (@(posedge mclk) disable iff (rst)
        (wr_en && idx == PFE_IDX) |=> ##1 payload_fec_on == $past(avs_writedata[7], 2))
        else $error("coding enable did not follow write");
    a_spacing_val: assert property (@(posedge mclk) disable iff (rst)
        $stable(mant_reg) && $stable(exp_reg) |=>
            spacing_reg == (12'h100 + {4'h0, $past(mant_reg)}) << $past(exp_reg))
        else $error("spacing formula wrong");
    a_oper_sum: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> oper_reg == {2'b00, $past(base_freq_word), 2'b00}
                 + {8'h00, 20'($past(spacing_reg)) * 20'($past(channel_number_reg))})
        else $error("operating frequency wrong");
    a_rsv_zero: assert property (@(posedge mclk) disable iff (rst)
        (avs_read && !ack_reg && idx == PFE_IDX) |=> rdata_reg[3:2] == 2'b00)
        else $error("reserved bits read nonzero");
    a_seen_sticky: assert property (@(posedge mclk) disable iff (rst)
        sync_pulse |=> seen_reg)
        else $error("sync event lost");

    // register file: reset values, writes landing, mantissa holding otherwise
    a_fec_reset: assert property (@(posedge mclk)
        $past(rst) |->
            fec_reg == FEC_RST && payload_fec_on == FEC_RST)
        else $error("coding enable reset wrong");
    a_spacing_reset: assert property (@(posedge mclk)
        $past(rst) |->
            exp_reg == 2'h2 && mant_reg == 8'hf8)
        else $error("spacing reset wrong");
    a_channel_number_reset: assert property (@(posedge mclk)
        $past(rst) |->
            channel_number_reg == CHANNEL_NUMBER_RST && !seen_reg)
        else $error("channel or status reset wrong");
    a_mode_write: assert property (@(posedge mclk) disable iff (rst)
        wr_mode |=>
            sync_mode_reg == $past(avs_writedata[2:0]))
        else $error("sync mode write lost");
    a_fec_write: assert property (@(posedge mclk) disable iff (rst)
        wr_pfe |=>
            fec_reg == $past(avs_writedata[7]))
        else $error("coding enable write lost");
    a_pre_write: assert property (@(posedge mclk) disable iff (rst)
        wr_pfe |=>
            pre_reg == $past(avs_writedata[6:4]))
        else $error("preamble write lost");
    a_exp_write: assert property (@(posedge mclk) disable iff (rst)
        wr_pfe |=>
            exp_reg == $past(avs_writedata[1:0]))
        else $error("exponent write lost");
    a_mant_write: assert property (@(posedge mclk) disable iff (rst)
        wr_mant |=>
            mant_reg == $past(avs_writedata[7:0]))
        else $error("mantissa write lost");
    a_channel_number_write: assert property (@(posedge mclk) disable iff (rst)
        wr_channel_number |=>
            channel_number_reg == $past(avs_writedata[7:0]))
        else $error("channel write lost");
    a_seen_clear: assert property (@(posedge mclk) disable iff (rst)
        (wr_stat && avs_writedata[0] && !sync_pulse) |=>
            !seen_reg)
        else $error("sync flag not cleared");
    a_mant_hold: assert property (@(posedge mclk) disable iff (rst)
        !wr_mant |=>
            $stable(mant_reg))
        else $error("mantissa changed unwritten");
endmodule // sfm_config_top

// ==== common/sfm_pkg.sv ====
// Behaviour
// - sync modes 000 and 100 send no sync word and search none
// - modes 001, 010, 101, 110 send and detect one 16-bit sync word
// - modes 001/101 accept 15 of 16 matching bits; 010/110 need all 16
// - modes 011/111 send the word twice; receive accepts 30 of 32 bits
// - modes 100 to 111 also need carrier sense above threshold
// - three-bit sync mode field is read/write and resets to 010
// - error correction enable resets to 0; 1 turns payload coding on
// - preamble code 0..7 gives 2,3,4,6,8,12,16,24 bytes; resets to 010
// - spacing is (256 + mantissa) shifted by exponent; resets 0xf8 and 10
// - unsigned spacing times channel number is added to base frequency
package sfm_pkg;
    localparam logic [15:0] SYNC_MODE_IDX = 16'hdf0e;
    localparam logic [15:0] PFE_IDX       = 16'hdf0f;
    localparam logic [15:0] MANT_IDX      = 16'hdf10;
    localparam logic [15:0] SYNC_HI_IDX   = 16'hdf00;
    localparam logic [15:0] SYNC_LO_IDX   = 16'hdf01;
    localparam logic [15:0] CHANNEL_NUMBER_IDX      = 16'hdf0a;
    localparam logic [15:0] STATUS_IDX    = 16'hdf20;

    localparam int FEC_BIT = 7;
    localparam int PRE_LSB = 4;
    localparam int EXP_LSB = 0;
    localparam int ST_SEEN_BIT = 0;
    localparam int ST_BUSY_BIT = 1;

    localparam logic [2:0] SYNC_MODE_RST = 3'h2;
    localparam logic       FEC_RST       = 1'b0;
    localparam logic [2:0] PRE_RST       = 3'h2;
    localparam logic [1:0] EXP_RST       = 2'h2;
    localparam logic [7:0] MANT_RST      = 8'hf8;
    localparam logic [7:0] SYNC_HI_RST   = 8'hd3;
    localparam logic [7:0] SYNC_LO_RST   = 8'h91;
    localparam logic [7:0] CHANNEL_NUMBER_RST      = 8'h00;

    localparam logic [7:0]  PREAMBLE_BYTE = 8'haa;
    localparam logic [11:0] SPACING_BASE  = 12'h100;
    localparam logic [5:0]  HITS16_LOOSE  = 6'h0f;
    localparam logic [5:0]  HITS16_FULL   = 6'h10;
    localparam logic [5:0]  HITS32_MIN    = 6'h1e;

    // number of sync words sent per frame for a sync mode
    function automatic logic [1:0] sfm_sync_words(input logic [2:0] m);
        case (m[1:0])
            2'h0:    return 2'h0;
            2'h3:    return 2'h2;
            default: return 2'h1;
        endcase
    endfunction

    function automatic logic [4:0] sfm_preamble_bytes(input logic [2:0] c);
        case (c)
            3'h0:    return 5'h02;
            3'h1:    return 5'h03;
            3'h2:    return 5'h04;
            3'h3:    return 5'h06;
            3'h4:    return 5'h08;
            3'h5:    return 5'h0c;
            3'h6:    return 5'h10;
            default: return 5'h18;
        endcase
    endfunction
endpackage

// ==== common/sfm_cfg_if.sv ====
`timescale 1ns/10ps
interface sfm_cfg_if;
    logic [2:0]  sync_mode;
    logic [2:0]  preamble_code;
    logic [15:0] sync_word;
    modport src  (output sync_mode, output preamble_code, output sync_word);
    modport sink (input sync_mode, input preamble_code, input sync_word);
endinterface // sfm_cfg_if

// ==== src/sfm_sync_detect.sv ====
`timescale 1ns/10ps
module sfm_sync_detect
    import sfm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    sfm_cfg_if.sink   cfg,
    input  wire logic rx_bit,
    input  wire logic rx_bit_valid,
    input  wire logic carrier_sense,
    output logic      sync_found
);
    logic [31:0] shift_reg;
    logic [31:0] shift_next;
    logic [5:0]  fill_reg;
    logic [5:0]  hits16;
    logic [5:0]  hits32;
    logic        hit;
    logic        qualified;
    logic        found_reg;

    function automatic logic [5:0] popcnt(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction

    assign shift_next = {shift_reg[30:0], rx_bit};

    always_comb begin
        hits16 = popcnt({16'h0000, ~(shift_next[15:0] ^ cfg.sync_word)});
        hits32 = popcnt(~(shift_next ^ {cfg.sync_word, cfg.sync_word}));
        case (cfg.sync_mode[1:0])
            2'h1:    hit = (fill_reg >= 6'h0f) && (hits16 >= HITS16_LOOSE);
            2'h2:    hit = (fill_reg >= 6'h0f) && (hits16 == HITS16_FULL);
            2'h3:    hit = (fill_reg >= 6'h1f) && (hits32 >= HITS32_MIN);
            default: hit = 1'b0;
        endcase
        qualified = hit && (!cfg.sync_mode[2] || carrier_sense);
    end

    // search restarts after each hit so one sync word gives one pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_reg <= 32'h0000_0000;
            fill_reg  <= 6'h00;
        end else if (rx_bit_valid) begin
            shift_reg <= shift_next;
            if (qualified)
                fill_reg <= 6'h00;
            else if (fill_reg != 6'h20)
                fill_reg <= fill_reg + 6'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            found_reg <= 1'b0;
        else
            found_reg <= rx_bit_valid && qualified;
    end

    assign sync_found = found_reg;

    a_no_sync_search: assert property (@(posedge mclk) disable iff (rst)
        (cfg.sync_mode[1:0] == 2'h0) |=> !sync_found)
        else $error("sync found while sync is off");
    a_cs_gates_sync: assert property (@(posedge mclk) disable iff (rst)
        sync_found |-> $past(!cfg.sync_mode[2] || carrier_sense))
        else $error("sync found without carrier sense");
    a_full_match16: assert property (@(posedge mclk) disable iff (rst)
        (sync_found && $past(cfg.sync_mode[1:0]) == 2'h2) |-> $past(hits16) == 6'h10)
        else $error("16/16 mode took a partial match");
    a_loose_match32: assert property (@(posedge mclk) disable iff (rst)
        (sync_found && $past(cfg.sync_mode[1:0]) == 2'h3) |-> $past(hits32) >= 6'h1e)
        else $error("32-bit sync with under 30 hits");
endmodule // sfm_sync_detect

// ==== src/sfm_tx_header.sv ====
`timescale 1ns/10ps
module sfm_tx_header
    import sfm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    sfm_cfg_if.sink         cfg,
    input  wire logic       start,
    output logic [7:0]      byte_data,
    output logic            byte_valid,
    input  wire logic       byte_ready,
    output logic            busy
);
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_PRE  = 3'b010,
        TX_SYNC = 3'b100
    } sfm_tx_state_t;

    sfm_tx_state_t state_reg;
    logic [4:0]    cnt_reg;
    logic [7:0]    data_reg;
    logic [15:0]   word_reg;
    logic [1:0]    words_reg;
    logic          hs;

    assign hs         = byte_valid && byte_ready;
    assign byte_valid = (state_reg != TX_IDLE);
    assign busy       = byte_valid;
    assign byte_data  = data_reg;

    // mode and word are latched at start so a mid-frame write cannot tear it
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= TX_IDLE;
            cnt_reg   <= 5'h00;
            data_reg  <= 8'h00;
            word_reg  <= 16'h0000;
            words_reg <= 2'h0;
        end else begin
            case (state_reg)
                TX_IDLE: begin
                    if (start) begin
                        state_reg <= TX_PRE;
                        cnt_reg   <= sfm_preamble_bytes(cfg.preamble_code);
                        data_reg  <= PREAMBLE_BYTE;
                        word_reg  <= cfg.sync_word;
                        words_reg <= sfm_sync_words(cfg.sync_mode);
                    end
                end
                TX_PRE: begin
                    if (hs) begin
                        if (cnt_reg != 5'h01) begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end else if (words_reg == 2'h0) begin
                            state_reg <= TX_IDLE;
                        end else begin
                            state_reg <= TX_SYNC;
                            cnt_reg   <= {2'h0, words_reg, 1'b0};
                            data_reg  <= word_reg[15:8];
                        end
                    end
                end
                TX_SYNC: begin
                    if (hs) begin
                        cnt_reg  <= cnt_reg - 5'h01;
                        data_reg <= cnt_reg[0] ? word_reg[15:8] : word_reg[7:0];
                        if (cnt_reg == 5'h01)
                            state_reg <= TX_IDLE;
                    end
                end
                default: state_reg <= TX_IDLE;
            endcase
        end
    end

    a_pre_count: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == TX_IDLE && start) |=>
            cnt_reg == sfm_preamble_bytes($past(cfg.preamble_code)))
        else $error("preamble count not loaded from code");
    a_no_sync_tx: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == TX_PRE && words_reg == 2'h0) |=> state_reg != TX_SYNC)
        else $error("sync sent while sync is off");
    a_sync_len: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == TX_IDLE && start && cfg.sync_mode[1:0] == 2'h3) |=> words_reg == 2'h2)
        else $error("repeated sync not chosen");
    a_sync_entry: assert property (@(posedge mclk) disable iff (rst)
        (state_reg == TX_PRE && hs && cnt_reg == 5'h01 && words_reg != 2'h0)
            |=> state_reg == TX_SYNC && cnt_reg == {2'h0, $past(words_reg), 1'b0})
        else $error("sync length wrong");
endmodule // sfm_tx_header

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import sfm_pkg::*;
    logic        mclk;
    logic        rst;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_bit;
    logic        rx_bit_valid;
    logic        carrier_sense;
    logic        sync_found;
    logic        tx_start;
    logic [7:0]  tx_byte;
    logic        tx_byte_valid;
    logic        tx_byte_ready;
    logic        tx_busy;
    logic        payload_fec_on;
    logic [23:0] base_freq_word;
    logic [11:0] channel_spacing_word;
    logic [27:0] oper_freq_word;
    int          miscompares;
    int          checks_done;
    logic [31:0] seed;
    logic [31:0] rd_q[$];
    logic [7:0]  tx_q[$];
    int          pre_n[8] = '{2, 3, 4, 6, 8, 12, 16, 24};

    sfm_config_top #(.ADDR_W(16)) DUT (
        .mclk                 (mclk),
        .rst                  (rst),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_writedata        (avs_writedata),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .rx_bit               (rx_bit),
        .rx_bit_valid         (rx_bit_valid),
        .carrier_sense        (carrier_sense),
        .sync_found           (sync_found),
        .tx_start             (tx_start),
        .tx_byte              (tx_byte),
        .tx_byte_valid        (tx_byte_valid),
        .tx_byte_ready        (tx_byte_ready),
        .tx_busy              (tx_busy),
        .payload_fec_on       (payload_fec_on),
        .base_freq_word       (base_freq_word),
        .channel_spacing_word (channel_spacing_word),
        .oper_freq_word       (oper_freq_word)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr_n_rd, input logic [15:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_write     <= wr_n_rd;
        avs_read      <= ~wr_n_rd;
        avs_writedata <= {24'h0, d};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask

    // read data is taken at the edge where waitrequest is sampled low
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            check(avs_readdata, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hxxxxxxxx);
    end

    // a header byte stands until the edge that takes it
    always @(negedge mclk) begin
        if (tx_byte_valid && tx_byte_ready)
            check({24'h0, tx_byte}, (tx_q.size() > 0) ? {24'h0, tx_q.pop_front()} : 32'hx);
    end

    // random back-pressure on the header sink
    always @(posedge mclk)
        tx_byte_ready <= 1'($random(seed));

    task automatic sync_case(input logic [2:0] m, input logic cs, input logic [31:0] flip,
                             input logic exp);
        logic [31:0] w;
        int          nb;
        w  = {16'hd391, 16'hd391} ^ flip;
        nb = (m[1:0] == 2'h3) ? 32 : 16;
        wr(SYNC_MODE_IDX, {5'h0, m});
        carrier_sense <= cs;
        for (int i = nb - 1; i >= 0; i--) begin
            rx_bit       <= w[i];
            rx_bit_valid <= 1'b1;
            @(posedge mclk);
            rx_bit_valid <= 1'b0;
            rx_bit       <= ~w[i];
            @(negedge mclk);
            if (i == 0)
                check({31'h0, sync_found}, {31'h0, exp});
            @(posedge mclk);
        end
    endtask

    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial begin
        logic [15:0] w;
        logic [7:0]  m8;
        logic [7:0]  c8;
        logic        f;
        logic [11:0] sp;
        logic [23:0] b24;
        int          k;
        seed = 32'h57e5d6b0;
        miscompares = 0;
        checks_done = 0;
        rst = 1'b1;
        {avs_read, avs_write, rx_bit, rx_bit_valid, carrier_sense, tx_start} = 6'h0;
        avs_address = 16'h0;
        avs_writedata = 32'h0;
        base_freq_word = 24'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(SYNC_MODE_IDX, 32'h2);
        rd(PFE_IDX, 32'h22);
        rd(MANT_IDX, 32'hf8);
        check(channel_spacing_word, 32'h7e0);
        check(payload_fec_on, 32'h0);
        wr(SYNC_MODE_IDX, 8'h5);
        rd(SYNC_MODE_IDX, 32'h5);
        wr(16'hdf3f, 8'h5a);
        rd(16'hdf3f, 32'h0);
        $display("test registers done");

        for (int i = 0; i < 8; i++) begin
            m8 = 8'($random(seed));
            c8 = 8'($random(seed));
            f = 1'($random(seed));
            b24 = 24'($random(seed));
            base_freq_word <= b24;
            wr(MANT_IDX, m8);
            wr(CHANNEL_NUMBER_IDX, c8);
            wr(PFE_IDX, {f, 3'h5, 2'h3, i[1:0]});
            rd(PFE_IDX, {24'h0, f, 3'h5, 2'h0, i[1:0]});
            repeat (3) @(posedge mclk);
            sp = {3'h0, 1'b1, m8} << i[1:0];
            check(channel_spacing_word, sp);
            check(oper_freq_word, {b24, 2'b00} + 28'(sp) * 28'(c8));
            check(payload_fec_on, f);
        end
        $display("test spacing done");

        for (int m = 0; m < 8; m++) begin
            w = 16'($random(seed));
            wr(SYNC_HI_IDX, w[15:8]);
            wr(SYNC_LO_IDX, w[7:0]);
            wr(SYNC_MODE_IDX, 8'(m));
            wr(PFE_IDX, {1'b0, m[2:0], 4'h2});
            for (int j = 0; j < pre_n[m]; j++)
                tx_q.push_back(PREAMBLE_BYTE);
            k = (m[1:0] == 2'h0) ? 0 : ((m[1:0] == 2'h3) ? 2 : 1);
            repeat (k) begin
                tx_q.push_back(w[15:8]);
                tx_q.push_back(w[7:0]);
            end
            tx_start <= 1'b1;
            @(posedge mclk);
            tx_start <= 1'b0;
            @(posedge mclk);
            // a start while busy must not restart or lengthen the frame
            tx_start <= 1'b1;
            @(posedge mclk);
            tx_start <= 1'b0;
            while (tx_busy !== 1'b0)
                @(negedge mclk);
            repeat (4) @(posedge mclk);
            check(tx_q.size(), 32'h0);
        end
        $display("test header done");

        wr(SYNC_HI_IDX, 8'hd3);
        wr(SYNC_LO_IDX, 8'h91);
        sync_case(3'h2, 1'b0, 32'h0, 1'b1);
        sync_case(3'h2, 1'b0, 32'h10, 1'b0);
        sync_case(3'h1, 1'b0, 32'h10, 1'b1);
        sync_case(3'h1, 1'b0, 32'h11, 1'b0);
        sync_case(3'h0, 1'b1, 32'h0, 1'b0);
        sync_case(3'h4, 1'b1, 32'h0, 1'b0);
        sync_case(3'h6, 1'b0, 32'h0, 1'b0);
        sync_case(3'h6, 1'b1, 32'h0, 1'b1);
        sync_case(3'h5, 1'b1, 32'h4, 1'b1);
        sync_case(3'h3, 1'b0, 32'h10001, 1'b1);
        sync_case(3'h7, 1'b1, 32'h2, 1'b1);
        sync_case(3'h3, 1'b0, 32'h10003, 1'b0);
        sync_case(3'h7, 1'b0, 32'h0, 1'b0);
        rd(STATUS_IDX, 32'h1);
        wr(STATUS_IDX, 8'h1);
        rd(STATUS_IDX, 32'h0);
        $display("test sync done");
        wrap_up();
    end
endmodule // testbench
